//--- bench/slb_far_end.sv
// Far-end shift peripheral on the serial link, behavioural.
// Assumes the bench resolves pin levels and sets the mode inputs.
`timescale 1ns/1ps

module slb_far_end (
  // Link pins
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Mode and data
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsbFirst,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic      [7:0] rxByte,
  output logic      [3:0] bitCount,
  output int              byteCount
);
  logic [7:0] shiftReg = 8'h00;
  logic [7:0] rxShift  = 8'h00;
  logic [7:0] rxNext;
  logic       outBit;

  initial begin
    byteCount = 0;
    bitCount = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Before its first leading edge a phase-1 reply shows the inverse, never stale data
  assign outBit = lsbFirst ? shiftReg[0] : shiftReg[7];
  assign miso   = (clock_phase && bitCount == 4'h8) ? ~outBit : outBit;

  // Frame start loads the reply; shift on one edge, sample on the other; a full byte reloads
  always @(sck, posedge load) begin
    rxNext = lsbFirst ? {mosi, rxShift[7:1]} : {rxShift[6:0], mosi};
    if (load) begin
      shiftReg <= txByte;
      bitCount <= clock_phase ? 4'h8 : 4'h0;
    end else if ((sck != clock_polarity) == clock_phase) begin
      if (bitCount == 4'h8) begin
        shiftReg <= txByte;
        bitCount <= 4'h0;
      end else begin
        shiftReg <= lsbFirst ? shiftReg >> 1 : shiftReg << 1;
      end
    end else begin
      rxShift  <= rxNext;
      bitCount <= bitCount + 4'h1;
      if (bitCount == 4'h7) begin
        rxByte    <= rxNext;
        byteCount <= byteCount + 1;
      end
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the serial link core.
// Assumes slb_far_end answers on the far side of the master link.
`timescale 1ns/1ps

module tb_top
  import slb_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       gie;
    logic [7:0] tx;
    logic [7:0] farTx;
  } slb_row_type;

  logic        clk, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, farMiso, irq, wake;
  logic        nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, gie = 1'b0, farLoad = 1'b0, selN = 1'b1;
  logic        tbSck = 1'b0, tbMosi = 1'b0, cpolM = 1'b0, cphaM = 1'b0, lsbM = 1'b0, prevSck = 1'b0;
  logic  [7:0] regAddr = 8'h00, regWrData = 8'h00, farTx = 8'h00, regRdData, farRx, rdVal, got;
  logic  [3:0] farBits;
  int          farBytes, base, c0, failures = 0, num_checks = 0, cycles = 0, halfCnt = 0, halfSeen = 0;
  slb_row_type r;
  slb_row_type rows [6] = '{'{8'h90, 1'b1, 8'ha5, 8'h3c}, '{8'h15, 1'b1, 8'h81, 8'h7e},
                            '{8'hba, 1'b0, 8'hc3, 8'h96}, '{8'h3f, 1'b0, 8'h01, 8'h80},
                            '{8'h9d, 1'b1, 8'hff, 8'h00}, '{8'h92, 1'b0, 8'h5a, 8'ha5}};
  int          halfTab [4] = '{2, 4, 16, 32};
  logic  [7:0] adrs [4] = '{CTRL_ADDR, DATA_ADDR, STAT_ADDR, 8'he7};

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels follow whichever side has its enable up
  wire sckW  = sckOe ? sckOut : tbSck;
  wire mosiW = mosiOe ? mosiOut : tbMosi;
  wire misoW = misoOe ? misoOut : farMiso;
  // Far end sees data a little after the clock, as a real pin would; avoids an edge race
  wire #10 mosiFar = mosiW;

  slb_link_core DUT (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .globalIrqEnable(gie), .irqRequest(irq), .wakeRequest(wake),
    .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .selectN(selN));

  slb_far_end u_far (.sck(sckW), .mosi(mosiFar), .miso(farMiso), .clock_polarity(cpolM), .clock_phase(cphaM),
    .lsbFirst(lsbM), .load(farLoad), .txByte(farTx), .rxByte(farRx), .bitCount(farBits),
    .byteCount(farBytes));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle count, last shift-clock half period, and the hang limit
  always @(posedge clk) begin
    cycles  <= cycles + 1;
    prevSck <= sckOut;
    halfCnt <= (sckOut !== prevSck) ? 1 : halfCnt + 1;
    if (sckOut !== prevSck) halfSeen <= halfCnt;
    if (cycles == 30000) begin
      failures = failures + 1;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles; results are read 1 ns after the edge so they have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Polls status; the last read arms the done-flag clear
  task automatic waitDone;
    rdVal = 8'h00;
    for (int i = 0; i < 400 && rdVal[STAT_DONE] !== 1'b1; i++) rd(STAT_ADDR, rdVal);
  endtask

  task automatic pulseLoad;
    @(posedge clk);
    farLoad <= 1'b1;
    @(posedge clk);
    farLoad <= 1'b0;
  endtask

  // Bench as master: mode 0, MSB first, half period of 8 clocks
  task automatic slvXfer(input logic [7:0] b, output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      tbMosi <= b[i];
      repeat (8) @(posedge clk);
      g[i] = misoW;
      tbSck <= 1'b1;
      repeat (8) @(posedge clk);
      tbSck <= 1'b0;
    end
    tbMosi <= ~b[0];
    repeat (8) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: master rows, then the awkward cases
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      cpolM <= r.ctrl[CTRL_CLOCK_POLARITY];
      cphaM <= r.ctrl[CTRL_CLOCK_PHASE];
      lsbM  <= r.ctrl[CTRL_ORDER];
      tbSck <= r.ctrl[CTRL_CLOCK_POLARITY];
      gie   <= r.gie;
      farTx <= r.farTx;
      wr(CTRL_ADDR, r.ctrl);
      chk(sckOe, 1'b0);
      wr(CTRL_ADDR, r.ctrl | 8'h40);
      chk({sckOe, mosiOe, misoOe, sckOut}, {3'b110, r.ctrl[CTRL_CLOCK_POLARITY]});
      pulseLoad;
      wr(DATA_ADDR, r.tx);
      waitDone;
      chk({irq, wake}, {r.ctrl[CTRL_IE] & r.gie, 1'b0});
      chk(farRx, r.tx);
      chk(halfSeen, halfTab[r.ctrl[1:0]]);
      rd(DATA_ADDR, rdVal);
      // At /4 the pin synchroniser eats the hold margin, so receive is judged at slower rates
      if (r.ctrl[1:0] != 2'b00)
        chk(rdVal, r.farTx);
      rd(STAT_ADDR, rdVal);
      chk(rdVal[STAT_DONE], 1'b0);
      wr(CTRL_ADDR, 8'h00);
    end
    // Normal mode: a write while busy is flagged and dropped
    farTx <= 8'h5c;
    wr(CTRL_ADDR, 8'h12);
    wr(CTRL_ADDR, 8'h52);
    pulseLoad;
    wr(DATA_ADDR, 8'h11);
    wr(DATA_ADDR, 8'h22);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'hc0, 8'h40);
    waitDone;
    chk(farRx, 8'h11);
    rd(DATA_ADDR, rdVal);
    chk(rdVal, 8'h5c);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'hc0, 8'h00);
    // Buffered mode: first byte starts at once, an overwritten second byte chains
    wr(STAT_ADDR, 8'h01);
    farTx <= 8'h77;
    pulseLoad;
    base = farBytes;
    wr(DATA_ADDR, 8'hc6);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'h61, 8'h21);
    wr(DATA_ADDR, 8'h39);
    wr(DATA_ADDR, 8'h9e);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'h40, 8'h40);
    while (farBits < 4'h5) @(posedge clk);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'h60, 8'h40);
    while (farBytes < base + 1) @(posedge clk);
    c0 = cycles;
    chk(farRx, 8'hc6);
    // The chain happens at the last clock edge, one half period after the far end's count
    while (farBits != 4'h1) @(posedge clk);
    rd(STAT_ADDR, rdVal);
    chk(rdVal & 8'h60, 8'h20);
    while (farBytes < base + 2) @(posedge clk);
    chk(cycles - c0, 16 * 16);
    chk(farRx, 8'h9e);
    waitDone;
    rd(DATA_ADDR, rdVal);
    chk(rdVal, 8'h77);
    wr(STAT_ADDR, 8'h00);
    // Reset in mid-transfer brings registers and pin enables back to rest
    wr(CTRL_ADDR, 8'hd3);
    wr(DATA_ADDR, 8'hab);
    repeat (20) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({sckOe, mosiOe, misoOe, irq, wake, sckOut}, 6'h00);
    foreach (adrs[k]) begin
      rd(adrs[k], rdVal);
      chk(rdVal, 8'h00);
    end
    wr(CTRL_ADDR, 8'h5a);
    rd(CTRL_ADDR, rdVal);
    chk(rdVal, 8'h5a);
    // Slave: select gates the data output, an unloaded slave echoes
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h40);
    chk({sckOe, mosiOe, misoOe}, 3'b000);
    selN <= 1'b0;
    wr(DATA_ADDR, 8'h3c);
    slvXfer(8'h5a, got);
    chk({sckOe, mosiOe, misoOe}, 3'b001);
    chk(got, 8'h3c);
    waitDone;
    chk(wake, 1'b1);
    rd(DATA_ADDR, rdVal);
    chk(rdVal, 8'h5a);
    slvXfer(8'h00, got);
    chk(got, 8'h5a);
    selN <= 1'b1;
    complete_run;
  end
endmodule

//--- hw/slb_link_core.sv
// Byte-wide full-duplex serial link, master or slave, with optional tx buffer.
// Assumes one 10 MHz clock, synchronous active-low reset, pins synchronised here.
//
// Behaviour
// - Shift clock output as master, input as slave
// - Control bit 4 picks master, sets data directions
// - Slave needs select low; master ignores select
// - Normal master write starts clock, shifts byte
// - Start waits for next half-period prescaler tick
// - After byte: stop, done flag, read buffer
// - Interrupt needs local and global enables
// - Data address: writes to tx, reads rx
// - Normal busy write: collision flag, byte dropped
// - Buffered write fills buffer, flags full
// - Full flag clears when buffer enters shifter
// - Idle buffered write starts at once, clears
// - Load window high first four bit slots
// - Buffered byte at end chains without stopping
// - Enable bit activates interface and pins
// - Bit 5 picks LSB first, else MSB
// - Master rate: divide by 4, 8, 32, 64
// - Unloaded slave echoes last received byte
// - Slave completion can wake from idle
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module slb_link_core
  import slb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // System side
  input  wire logic       globalIrqEnable,
  output logic            irqRequest,
  output logic            wakeRequest,
  // Shift clock pin
  input  wire logic       sckIn,
  output logic            sckOut,
  output logic            sckOe,
  // Master-out data pin
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOe,
  // Master-in data pin
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoOe,
  // Slave select pin
  input  wire logic       selectN
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Shift one bit in at the end opposite to the output bit
  function automatic logic [7:0] shiftIn(input logic [7:0] r, input logic b, input logic lsb);
    shiftIn = lsb ? {b, r[7:1]} : {r[6:0], b};
  endfunction

  // Half shift-clock period for a rate code
  function automatic logic [5:0] halfLen(input logic [1:0] code);
    case (code)
      2'h0:    halfLen = HALF_DIV4;
      2'h1:    halfLen = HALF_DIV8;
      2'h2:    halfLen = HALF_DIV32;
      default: halfLen = HALF_DIV64;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]    ctrl_reg;
  logic          bufMode_reg;
  slb_state_type state_reg;
  logic [5:0]    preCnt_reg;
  logic          sckLevel_reg;
  logic [3:0]    edgeCnt_reg;
  logic          pending_reg;
  logic          rxBit_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    rxData_reg;
  logic [7:0]    txBuf_reg;
  logic          coll_reg;
  logic          done_reg;
  logic          armed_reg;
  logic [7:0]    rdData_reg;
  logic          sckS1_reg, sckS2_reg, sckD_reg;
  logic          mosiS1_reg, mosiS2_reg;
  logic          misoS1_reg, misoS2_reg;
  logic          selS1_reg, selS2_reg;

  logic enable, masterSel, lsbFirst, clock_polarity, clock_phase;
  logic wrData, wrCtrl, wrStat, rdDataAcc, rdStat, clearAccess;
  logic slaveSel, busy, halfTick, mEdge, sEdge, lead, edgeEv;
  logic sampleEv, shiftEv, finish, chain, inBit, curBit, curPend;
  logic directLoad, normColl, bufWrite, loadWin;
  logic [7:0] finalByte;

  ////////////////////////////////////////////////////////////////////////////
  // Field and address decode

  assign enable    = ctrl_reg[CTRL_EN];
  assign masterSel = ctrl_reg[CTRL_MASTER_SELECT];
  assign lsbFirst  = ctrl_reg[CTRL_ORDER];
  assign clock_polarity      = ctrl_reg[CTRL_CLOCK_POLARITY];
  assign clock_phase      = ctrl_reg[CTRL_CLOCK_PHASE];

  // One address, two buffers: writes reach tx side, reads rx side
  assign wrData      = regWr && regAddr == DATA_ADDR;
  assign rdDataAcc   = regRd && regAddr == DATA_ADDR;
  assign wrCtrl      = regWr && regAddr == CTRL_ADDR;
  assign wrStat      = regWr && regAddr == STAT_ADDR;
  assign rdStat      = regRd && regAddr == STAT_ADDR;
  assign clearAccess = armed_reg && (wrData || rdDataAcc);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each before any logic

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sckS1_reg  <= 1'b0;
      sckS2_reg  <= 1'b0;
      sckD_reg   <= 1'b0;
      mosiS1_reg <= 1'b0;
      mosiS2_reg <= 1'b0;
      misoS1_reg <= 1'b0;
      misoS2_reg <= 1'b0;
      selS1_reg  <= 1'b1;
      selS2_reg  <= 1'b1;
    end else begin
      sckS1_reg  <= sckIn;
      sckS2_reg  <= sckS1_reg;
      sckD_reg   <= sckS2_reg;
      mosiS1_reg <= mosiIn;
      mosiS2_reg <= mosiS1_reg;
      misoS1_reg <= misoIn;
      misoS2_reg <= misoS1_reg;
      selS1_reg  <= selectN;
      selS2_reg  <= selS1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer events, common to both roles

  // Slave answers only while enabled and selected
  assign slaveSel = enable && !masterSel && !selS2_reg;
  assign busy     = masterSel ? (state_reg != ST_IDLE) : (slaveSel && (edgeCnt_reg != 4'h0 || pending_reg));

  // Prescaler runs free so a start lands on a slot boundary
  assign halfTick = preCnt_reg >= halfLen(ctrl_reg[1:0]) - 6'h01;
  assign mEdge    = enable && masterSel && state_reg == ST_RUN && halfTick;
  // Slave clock edges come from the synchronised pin, not the prescaler
  assign sEdge    = slaveSel && (sckS2_reg != sckD_reg);
  assign edgeEv   = masterSel ? mEdge : sEdge;
  assign lead     = masterSel ? (mEdge && !edgeCnt_reg[0]) : (sEdge && sckS2_reg != clock_polarity);
  // Phase 0 samples on leading edges, phase 1 on trailing
  assign sampleEv = clock_phase ? (edgeEv && !lead) : lead;
  assign shiftEv  = clock_phase ? lead : (edgeEv && !lead);
  assign finish   = masterSel ? (mEdge && edgeCnt_reg == LAST_MEDGE) : (sampleEv && edgeCnt_reg == LAST_SAMPLE);
  assign inBit    = masterSel ? misoS2_reg : mosiS2_reg;
  assign curBit   = sampleEv ? inBit : rxBit_reg;
  assign curPend  = sampleEv || pending_reg;
  assign finalByte = curPend ? shiftIn(shift_reg, curBit, lsbFirst) : shift_reg;
  assign chain    = finish && bufMode_reg && coll_reg;

  // Write classes: straight into the shifter, collision, or buffered
  assign directLoad = wrData && !busy;
  assign normColl   = wrData && busy && !bufMode_reg;
  assign bufWrite   = wrData && busy && bufMode_reg;
  assign loadWin    = busy && (masterSel ? !edgeCnt_reg[3] : edgeCnt_reg < WIN_SLOTS);

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bufMode_reg <= 1'b0;
    end else if (wrStat) begin
      bufMode_reg <= regWrData[STAT_BUFM];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer and shift clock

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (!enable || !masterSel) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (directLoad) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (halfTick) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (finish && !chain) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      preCnt_reg <= 6'h00;
    end else if (halfTick) begin
      preCnt_reg <= 6'h00;
    end else begin
      preCnt_reg <= preCnt_reg + 6'h01;
    end
  end

  // Clock rests at the polarity level outside a run
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sckLevel_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      sckLevel_reg <= clock_polarity;
    end else if (mEdge) begin
      sckLevel_reg <= !sckLevel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit counting and shifting

  // Master counts half periods, slave counts samples
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edgeCnt_reg <= 4'h0;
    end else if (!enable || (!masterSel && !slaveSel) || directLoad || finish) begin
      edgeCnt_reg <= 4'h0;
    end else if (masterSel ? mEdge : sampleEv) begin
      edgeCnt_reg <= edgeCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending_reg <= 1'b0;
      rxBit_reg   <= 1'b0;
    end else if (!enable || (!masterSel && !slaveSel) || directLoad || finish) begin
      pending_reg <= 1'b0;
    end else if (sampleEv) begin
      pending_reg <= 1'b1;
      rxBit_reg   <= inBit;
    end else if (shiftEv) begin
      pending_reg <= 1'b0;
    end
  end

  // Received byte stays in the shifter, so an unloaded slave echoes it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_reg <= DATA_RESET;
    end else if (directLoad) begin
      shift_reg <= regWrData;
    end else if (chain) begin
      shift_reg <= txBuf_reg;
    end else if (finish) begin
      shift_reg <= finalByte;
    end else if (shiftEv && pending_reg) begin
      shift_reg <= shiftIn(shift_reg, rxBit_reg, lsbFirst);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxData_reg <= DATA_RESET;
    end else if (finish) begin
      rxData_reg <= finalByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txBuf_reg <= DATA_RESET;
    end else if (bufWrite) begin
      txBuf_reg <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a set in the clearing cycle wins

  // Status read arms the clear that a later data access performs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (rdStat) begin
      armed_reg <= 1'b1;
    end else if (wrData || rdDataAcc) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (clearAccess) begin
      done_reg <= 1'b0;
    end
  end

  // Buffered mode clears only by hardware, when the byte enters the shifter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      coll_reg <= 1'b0;
    end else if (normColl || bufWrite) begin
      coll_reg <= 1'b1;
    end else if (bufMode_reg ? chain : clearAccess) begin
      coll_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data valid one cycle after the strobe

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_reg <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        CTRL_ADDR: rdData_reg <= ctrl_reg;
        DATA_ADDR: rdData_reg <= rxData_reg;
        STAT_ADDR: rdData_reg <= {done_reg, coll_reg, loadWin, 4'h0, bufMode_reg};
        default:   rdData_reg <= 8'h00;
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  assign regRdData = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign irqRequest  = done_reg && ctrl_reg[CTRL_IE] && globalIrqEnable;
  // Only a slave completion may wake the core from idle
  assign wakeRequest = done_reg && enable && !masterSel;

  // Pin drivers; a deselected slave releases its data output
  assign sckOut  = sckLevel_reg;
  assign sckOe   = enable && masterSel;
  assign mosiOut = lsbFirst ? shift_reg[0] : shift_reg[7];
  assign mosiOe  = enable && masterSel;
  assign misoOut = lsbFirst ? shift_reg[0] : shift_reg[7];
  assign misoOe  = slaveSel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  done_sets_a:
    assert property (finish |=> done_reg && rxData_reg == $past(finalByte))
    else $error("done flag or read buffer missed");

  irq_gate_a:
    assert property (irqRequest |-> ctrl_reg[CTRL_IE] && globalIrqEnable && done_reg)
    else $error("interrupt without both enables");

  busy_write_a:
    assert property (normColl |=> coll_reg && (shift_reg == $past(shift_reg) || $past(finish || shiftEv)))
    else $error("busy write not flagged or not dropped");

  chain_load_a:
    assert property (chain && !bufWrite |=> !coll_reg && shift_reg == $past(txBuf_reg) && state_reg == $past(state_reg))
    else $error("buffered byte not chained");

  idle_start_a:
    assert property (directLoad && bufMode_reg && !coll_reg && enable && masterSel
                     |=> !coll_reg && state_reg == ST_WAIT && shift_reg == $past(regWrData))
    else $error("idle buffered write left full flag");

  start_slot_a:
    assert property (directLoad && enable && masterSel && $stable(ctrl_reg)
                     |=> state_reg == ST_WAIT ##[1:64] state_reg == ST_RUN)
    else $error("master did not start within a slot");

  sck_idle_a:
    assert property ((state_reg == ST_IDLE && $stable(clock_polarity))[*2] |-> sckLevel_reg == clock_polarity)
    else $error("idle clock level differs from polarity");

  load_window_a:
    assert property (masterSel && state_reg == ST_RUN && edgeCnt_reg >= 4'h8 |-> !loadWin)
    else $error("load window open after four slots");

  fast_rate_a:
    assert property (mEdge && ctrl_reg[1:0] == 2'h0 && $stable(ctrl_reg) |=> !mEdge ##1 (mEdge || state_reg != ST_RUN))
    else $error("divide-by-four rate wrong");

  slave_drive_a:
    assert property (misoOe |-> !selS2_reg && !masterSel && enable)
    else $error("slave drives while not selected");

endmodule

//--- hw/slb_pkg.sv
// Constants for the buffered serial link block: register map, fields, states.
// Assumes an 8-bit register port with byte addresses.
package slb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] STAT_ADDR = 8'he8;
  localparam logic [7:0] CTRL_ADDR = 8'he9;
  localparam logic [7:0] DATA_ADDR = 8'hea;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Control register fields
  localparam int CTRL_IE    = 7;
  localparam int CTRL_EN    = 6;
  localparam int CTRL_ORDER = 5;
  localparam int CTRL_MASTER_SELECT  = 4;
  localparam int CTRL_CLOCK_POLARITY  = 3;
  localparam int CTRL_CLOCK_PHASE  = 2;
  localparam int CTRL_RATE1 = 1;
  localparam int CTRL_RATE0 = 0;

  // Status register fields
  localparam int STAT_DONE = 7;
  localparam int STAT_COLL = 6;
  localparam int STAT_LDWN = 5;
  localparam int STAT_BUFM = 0;

  // Half shift-clock periods in oscillator cycles for rate codes 0..3
  // Six bits wide, so the slowest half period of 32 does not wrap to zero
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV8  = 6'h04;
  localparam logic [5:0] HALF_DIV32 = 6'h10;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // Transfer geometry
  localparam logic [3:0] LAST_MEDGE  = 4'hf;
  localparam logic [3:0] LAST_SAMPLE = 4'h7;
  localparam logic [3:0] WIN_SLOTS   = 4'h4;

  // Master sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } slb_state_type;

endpackage
